/* File: ast_map.vh */
// register map and timing constants for the self-test timing block
`ifndef AST_MAP_VH
`define AST_MAP_VH

// ----------------------------------------
// register indexes; byte address is four times the index
// ----------------------------------------
`define AST_OFF_INT_EN       12'h0020
`define AST_OFF_PIN_ROUTE    12'h0021
`define AST_OFF_MAIN_CFG     12'h0015
`define AST_OFF_RATE_CFG     12'h0018
`define AST_OFF_IDLE_PHASE_LEN      12'h0037
`define AST_OFF_MEAS_DECIMATION_SEL       12'h0038
`define AST_OFF_STATUS       12'h0040
`define AST_IDX_NONE         12'hfff

// ----------------------------------------
// field positions
// ----------------------------------------
`define AST_IE_DRDY          7
`define AST_IE_SAMPLE_CHANGE_DETECTOR_OT       5
`define AST_MAIN_ACTIVE      0
`define AST_MAIN_POL         5
`define AST_MAIN_AXIS_LO     6
`define AST_MAIN_AXIS_HI     7
`define AST_DEC_W            4
`define AST_IDLE_W           5

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define AST_IE_RST_GND       8'h00
`define AST_IE_RST_VDD       8'h20
`define AST_CFG_RST          8'h00
`define AST_AXIS_OFF         2'h0
`define AST_DEC_MAX          4'hc

// ----------------------------------------
// timing: base phase 312.5 us, idle step 31.25 us, in ps
// ----------------------------------------
`define AST_BASE_PS          64'd312500000
`define AST_STEP_PS          64'd31250000
`define AST_CLK_PS           64'd8000

// ----------------------------------------
// bus responses
// ----------------------------------------
`define AST_RESP_OKAY        2'h0
`define AST_RESP_SLVERR      2'h2

`endif

/* File: ast_period_gen.v */
// self-test measurement period generator
`timescale 1ns/1ps
module ast_period_gen #(
    parameter BASE_CYC = 39063,
    parameter STEP_CYC = 3907,
    parameter CNT_W = 32
)
(
    input wire aclk,
    input wire aresetn,
    input wire restart,
    input wire run,
    input wire [3:0] dec_code,
    input wire [4:0] idle_len,
    output reg sample_tick
);
`include "ast_map.vh"

    reg [CNT_W-1:0] cyc_reg;
    reg [12:0] samp_reg;
    wire [CNT_W-1:0] phase_cyc;
    wire [12:0] dec_count;

    // codes above 12 saturate at 4096 samples
    function [12:0] ast_dec_count;
        input [3:0] code;
        begin
            if (code >= `AST_DEC_MAX)
                ast_dec_count = 13'h1000;
            else
                ast_dec_count = 13'h0001 << code;
        end
    endfunction

    assign phase_cyc = BASE_CYC[CNT_W-1:0] + STEP_CYC[CNT_W-1:0] * {{(CNT_W-5){1'b0}}, idle_len};
    assign dec_count = ast_dec_count(dec_code);

    always @(posedge aclk)
    begin
        if (!aresetn || restart || !run)
        begin
            // counting restarts at each entry to active mode
            cyc_reg <= {CNT_W{1'b0}};
            samp_reg <= 13'h0000;
            sample_tick <= 1'b0;
        end
        else if (cyc_reg + {{(CNT_W-1){1'b0}}, 1'b1} >= phase_cyc)
        begin
            cyc_reg <= {CNT_W{1'b0}};
            if (samp_reg + 13'h0001 >= dec_count)
            begin
                samp_reg <= 13'h0000;
                sample_tick <= 1'b1;
            end
            else
            begin
                samp_reg <= samp_reg + 13'h0001;
                sample_tick <= 1'b0;
            end
        end
        else
        begin
            cyc_reg <= cyc_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            sample_tick <= 1'b0;
        end
    end
endmodule

/* File: ast_self_test.v */
// self-test timing, interrupt enable and axi4-lite register block
//
// Summary of operation
// - four-bit decimation field selects 1 to 4096 samples per measurement phase
// - codes 0..12 give two to the code samples; 12..15 give 4096
// - reset default code zero, idle zero gives 312.5 us period
// - period equals two to code times base plus idle steps
// - user rate and power settings ignored while self-test engaged
// - axis select 00 restores user rate and power mode
// - interrupt enable register at 20h, eight read/write bits, seven of them event enables (bit 1 gates nothing)
// - enable register resets zero, or bit 5 set when strap high
// - bit 7 gates the data-ready event
// - enabled events drive line one or two per routing register
// - bit 5 gates the outside-threshold change event
// - idle field in bits 4..0, 312.5 us plus 31.25 us per count
// - axis select 01 x, 10 y, 11 z, 00 off
// - polarity bit 0 positive, 1 negative deflection
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module ast_self_test #(
    parameter BASE_CYC = 39063,
    parameter STEP_CYC = 3907
)
(
    input wire aclk,
    input wire aresetn,
    input wire boot_strap_mode,
    input wire sample_change_detector_outside_evt,
    input wire sample_change_detector_within_evt,
    input wire orient_evt,
    input wire autosleep_evt,
    input wire buffer_evt,
    input wire wake_evt,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg irq_line_one,
    output reg irq_line_two,
    output reg [1:0] test_axis_select,
    output reg deflection_polarity,
    output reg [7:0] eff_rate_cfg,
    output reg self_test_on,
    output reg sample_tick_out
);
`include "ast_map.vh"

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] interrupt_enable_reg;
    reg [7:0] pin_route_reg;
    reg [7:0] sensor_main_cfg_reg;
    reg [7:0] sensor_rate_cfg_reg;
    reg [4:0] idle_phase_len_reg;
    reg [3:0] meas_decimation_sel_reg;
    reg drdy_flag_reg;
    reg active_d_reg;
    reg strap_done_reg;
    reg [11:0] aw_addr_reg;
    reg aw_have_reg;
    reg [31:0] w_data_reg;
    reg w_have_reg;
    reg [3:0] w_strb_reg;
    wire sample_tick;
    wire active_now;
    wire st_engaged;
    wire enter_active;
    wire wr_fire;
    wire [7:0] ev_vec;
    wire [7:0] ev_gated;
    wire [7:0] ev_to_two;
    wire [7:0] idle_merged;
    wire [11:0] ar_index;

    assign active_now = sensor_main_cfg_reg[`AST_MAIN_ACTIVE];
    assign st_engaged = sensor_main_cfg_reg[`AST_MAIN_AXIS_HI:`AST_MAIN_AXIS_LO] != `AST_AXIS_OFF;
    assign enter_active = active_now && !active_d_reg;
    assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // one register per aligned word; a misaligned address maps to no register
    function [11:0] ast_index;
        input [11:0] addr;
        begin
            if (addr[1:0] != 2'h0)
                ast_index = `AST_IDX_NONE;
            else
                ast_index = {2'h0, addr[11:2]};
        end
    endfunction

    // status takes a write without error but keeps nothing from it
    function ast_mapped;
        input [11:0] idx;
        begin
            if (idx == `AST_OFF_INT_EN || idx == `AST_OFF_PIN_ROUTE)
                ast_mapped = 1'b1;
            else if (idx == `AST_OFF_MAIN_CFG || idx == `AST_OFF_RATE_CFG)
                ast_mapped = 1'b1;
            else if (idx == `AST_OFF_IDLE_PHASE_LEN || idx == `AST_OFF_MEAS_DECIMATION_SEL || idx == `AST_OFF_STATUS)
                ast_mapped = 1'b1;
            else
                ast_mapped = 1'b0;
        end
    endfunction

    // both channels decode on the index so they share one map
    assign ar_index = ast_index(s_axi_araddr);

    // ----------------------------------------
    // period generator
    // ----------------------------------------
    ast_period_gen #(
        .BASE_CYC(BASE_CYC),
        .STEP_CYC(STEP_CYC),
        .CNT_W(32)
    ) u_period (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(enter_active),
        .run(active_now),
        .dec_code(meas_decimation_sel_reg),
        .idle_len(idle_phase_len_reg),
        .sample_tick(sample_tick)
    );

    // ----------------------------------------
    // write channel: address and data in either order
    // ----------------------------------------
    function [7:0] ast_merge;
        input [7:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            ast_merge = strb[0] ? data[7:0] : old;
        end
    endfunction
    assign idle_merged = ast_merge({3'h0, idle_phase_len_reg}, w_data_reg, w_strb_reg);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AST_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= ast_index(s_axi_awaddr);
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                // strobes are kept with the data; the master may change them once taken
                w_strb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (ast_mapped(aw_addr_reg))
                    s_axi_bresp <= `AST_RESP_OKAY;
                else
                    s_axi_bresp <= `AST_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            // strap cannot feed the reset value directly; caught after release
            interrupt_enable_reg <= `AST_IE_RST_GND;
            strap_done_reg <= 1'b0;
            pin_route_reg <= `AST_CFG_RST;
            sensor_main_cfg_reg <= `AST_CFG_RST;
            sensor_rate_cfg_reg <= `AST_CFG_RST;
            idle_phase_len_reg <= 5'h00;
            meas_decimation_sel_reg <= 4'h0;
        end
        else
        begin
            strap_done_reg <= 1'b1;
            if (!strap_done_reg)
                interrupt_enable_reg <= boot_strap_mode ? `AST_IE_RST_VDD : `AST_IE_RST_GND;
            if (wr_fire)
            begin
                if (aw_addr_reg == `AST_OFF_INT_EN)
                    interrupt_enable_reg <= ast_merge(interrupt_enable_reg, w_data_reg, w_strb_reg);
                else if (aw_addr_reg == `AST_OFF_PIN_ROUTE)
                    pin_route_reg <= ast_merge(pin_route_reg, w_data_reg, w_strb_reg);
                else if (aw_addr_reg == `AST_OFF_MAIN_CFG)
                    sensor_main_cfg_reg <= ast_merge(sensor_main_cfg_reg, w_data_reg, w_strb_reg);
                else if (aw_addr_reg == `AST_OFF_RATE_CFG)
                    sensor_rate_cfg_reg <= ast_merge(sensor_rate_cfg_reg, w_data_reg, w_strb_reg);
                else if (aw_addr_reg == `AST_OFF_IDLE_PHASE_LEN)
                    idle_phase_len_reg <= idle_merged[`AST_IDLE_W-1:0];
                else if (aw_addr_reg == `AST_OFF_MEAS_DECIMATION_SEL)
                    meas_decimation_sel_reg <= w_data_reg[`AST_DEC_W-1:0] & {4{w_strb_reg[0]}}
                        | meas_decimation_sel_reg & {4{!w_strb_reg[0]}};
            end
        end
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AST_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `AST_RESP_OKAY;
                if (ar_index == `AST_OFF_INT_EN)
                    s_axi_rdata <= {24'h00_0000, interrupt_enable_reg};
                else if (ar_index == `AST_OFF_PIN_ROUTE)
                    s_axi_rdata <= {24'h00_0000, pin_route_reg};
                else if (ar_index == `AST_OFF_MAIN_CFG)
                    s_axi_rdata <= {24'h00_0000, sensor_main_cfg_reg};
                else if (ar_index == `AST_OFF_RATE_CFG)
                    s_axi_rdata <= {24'h00_0000, sensor_rate_cfg_reg};
                else if (ar_index == `AST_OFF_IDLE_PHASE_LEN)
                    s_axi_rdata <= {27'h000_0000, idle_phase_len_reg};
                else if (ar_index == `AST_OFF_MEAS_DECIMATION_SEL)
                    s_axi_rdata <= {28'h000_0000, meas_decimation_sel_reg};
                else if (ar_index == `AST_OFF_STATUS)
                    s_axi_rdata <= {30'h0000_0000, st_engaged, drdy_flag_reg};
                else
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `AST_RESP_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // data-ready flag, event gating and pin routing
    // ----------------------------------------
    // flag cleared by a status read; a new sample in the same cycle wins
    always @(posedge aclk)
    begin
        if (!aresetn)
            drdy_flag_reg <= 1'b0;
        else if (sample_tick)
            drdy_flag_reg <= 1'b1;
        else if (s_axi_arvalid && s_axi_arready && ar_index == `AST_OFF_STATUS)
            drdy_flag_reg <= 1'b0;
    end

    assign ev_vec = {drdy_flag_reg, buffer_evt, sample_change_detector_outside_evt, sample_change_detector_within_evt,
                     orient_evt, autosleep_evt, 1'b0, wake_evt};
    // bit 1 is a disable, not an event source
    assign ev_gated = ev_vec & interrupt_enable_reg & 8'hfd;
    assign ev_to_two = ev_gated & pin_route_reg;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            active_d_reg <= 1'b0;
            irq_line_one <= 1'b0;
            irq_line_two <= 1'b0;
            test_axis_select <= `AST_AXIS_OFF;
            deflection_polarity <= 1'b0;
            eff_rate_cfg <= `AST_CFG_RST;
            self_test_on <= 1'b0;
            sample_tick_out <= 1'b0;
        end
        else
        begin
            active_d_reg <= active_now;
            irq_line_one <= |(ev_gated & ~pin_route_reg);
            irq_line_two <= |ev_to_two;
            test_axis_select <= sensor_main_cfg_reg[`AST_MAIN_AXIS_HI:`AST_MAIN_AXIS_LO];
            deflection_polarity <= sensor_main_cfg_reg[`AST_MAIN_POL];
            // self-test overrides the user rate and power choice
            eff_rate_cfg <= st_engaged ? `AST_CFG_RST : sensor_rate_cfg_reg;
            self_test_on <= st_engaged && active_now;
            sample_tick_out <= sample_tick;
        end
    end
endmodule

/* File: ast_host_model.sv */
// host-side tracker of which self-test samples may be used
`timescale 1ns/1ps
module ast_host_model (
    input wire aclk,
    input wire restart,
    input wire sample_tick,
    input wire [3:0] dec_code,
    output reg sample_ok
);
    reg [2:0] tick_cnt = 3'h0;
    // early samples are still settling, so slow rates need fewer discards
    wire [2:0] need = (dec_code == 4'h0) ? 3'h4 : (dec_code == 4'h1) ? 3'h3 : (dec_code < 4'h5) ? 3'h2 : 3'h1;
    always @(posedge aclk)
    begin
        if (restart)
            tick_cnt <= 3'h0;
        else if (sample_tick && tick_cnt != 3'h7)
            tick_cnt <= tick_cnt + 3'h1;
    end
    always @*
    begin
        sample_ok = tick_cnt >= need;
    end
endmodule

/* File: ast_self_test_properties.sv */
// port checks for the self-test timing block
`timescale 1ns/1ps
module ast_st_checker (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire irq_line_one,
    input wire irq_line_two,
    input wire [1:0] test_axis_select,
    input wire [7:0] eff_rate_cfg,
    input wire self_test_on,
    input wire sample_tick_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rst_quiet_a: assert property ($rose(aresetn) |-> !irq_line_one && !irq_line_two && !self_test_on && !sample_tick_out)
        else $error("outputs busy after reset");
    rate_override_a: assert property (test_axis_select != 2'h0 |-> eff_rate_cfg == 8'h00)
        else $error("user rate leaks during self-test");
    axis_engaged_a: assert property (self_test_on |-> test_axis_select != 2'h0)
        else $error("self-test on with no axis");
    tick_gap_a: assert property (sample_tick_out |=> !sample_tick_out [*3])
        else $error("sample ticks too close");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
        else $error("bad write response code");
endmodule
bind ast_self_test ast_st_checker chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_line_one(irq_line_one), .irq_line_two(irq_line_two),
    .test_axis_select(test_axis_select), .eff_rate_cfg(eff_rate_cfg), .self_test_on(self_test_on),
    .sample_tick_out(sample_tick_out));

/* File: accel_self_test_timing_tb.sv */
// bench for the self-test timing block
`timescale 1ns/1ps
`include "ast_map.vh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module accel_self_test_timing_tb;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg boot_strap_mode = 1'b0;
    reg host_rst = 1'b0;
    reg [7:0] ev = 8'h00;
    reg [11:0] s_axi_awaddr = 12'h000;
    reg [11:0] s_axi_araddr = 12'h000;
    reg [31:0] s_axi_wdata = 32'h0000_0000;
    reg s_axi_awvalid = 1'b0;
    reg s_axi_wvalid = 1'b0;
    reg s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0;
    reg s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, test_axis_select;
    wire [31:0] s_axi_rdata;
    wire [7:0] eff_rate_cfg;
    wire irq_line_one, irq_line_two, deflection_polarity, self_test_on, sample_tick_out, sample_ok;
    integer err_total = 0;
    integer n_checks = 0;
    integer k, j, c0, c1, p;
    reg [31:0] d;
    reg [1:0] r;
    reg [3:0] dec_t [0:3] = '{4'h0, 4'h1, 4'h2, 4'hd};
    always #4 aclk = ~aclk;
    // short base and step keep the longest period near 16k cycles
    ast_self_test #(.BASE_CYC(4), .STEP_CYC(1)) dut (.aclk(aclk), .aresetn(aresetn),
        .boot_strap_mode(boot_strap_mode), .sample_change_detector_outside_evt(ev[5]), .sample_change_detector_within_evt(ev[4]),
        .orient_evt(ev[3]), .autosleep_evt(ev[2]), .buffer_evt(ev[6]), .wake_evt(ev[0]),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq_line_one(irq_line_one), .irq_line_two(irq_line_two),
        .test_axis_select(test_axis_select), .deflection_polarity(deflection_polarity),
        .eff_rate_cfg(eff_rate_cfg), .self_test_on(self_test_on), .sample_tick_out(sample_tick_out));
    ast_host_model host (.aclk(aclk), .restart(host_rst), .sample_tick(sample_tick_out),
        .dec_code(4'h0), .sample_ok(sample_ok));
    task test_done;
        begin
            if (err_total == 0 && n_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task hang(input bit t);
        begin
            if (t)
            begin
                err_total++;
                $display("wrong value wait expected %h seen %h", 1'b1, 1'b0);
                test_done;
            end
        end
    endtask
    task axi_wr(input [11:0] a, input [7:0] v);
        integer i;
        begin
            @(posedge aclk);
            s_axi_awaddr <= {a[9:0], 2'h0};
            s_axi_wdata <= {24'h00_0000, v};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            for (i = 0; i < 300; i++)
            begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid) break;
            end
            s_axi_bready <= 1'b0;
            hang(i == 300);
        end
    endtask
    task axi_rd(input [11:0] a, output [31:0] v, output [1:0] rr);
        integer i;
        begin
            @(posedge aclk);
            s_axi_araddr <= {a[9:0], 2'h0};
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            for (i = 0; i < 300; i++)
            begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid) break;
            end
            v = s_axi_rdata;
            rr = s_axi_rresp;
            s_axi_rready <= 1'b0;
            hang(i == 300);
        end
    endtask
    task wait_tick(output integer c);
        begin
            for (c = 1; c <= 40000; c++)
            begin
                @(posedge aclk);
                if (sample_tick_out) break;
            end
            hang(c > 40000);
        end
    endtask
    initial
    begin
        for (k = 0; k < 2; k++)
        begin
            @(posedge aclk);
            aresetn <= 1'b0;
            boot_strap_mode <= k[0];
            repeat (10) @(posedge aclk);
            aresetn <= 1'b1;
            repeat (3) @(posedge aclk);
            axi_rd(`AST_OFF_INT_EN, d, r);
            `CHK("int enable reset", k ? 8'h20 : 8'h00, d[7:0])
        end
        axi_rd(`AST_OFF_MEAS_DECIMATION_SEL, d, r);
        `CHK("decimation reset", 8'h00, d[7:0])
        axi_wr(`AST_OFF_INT_EN, 8'h5a);
        axi_rd(`AST_OFF_INT_EN, d, r);
        `CHK("int enable", 8'h5a, d[7:0])
        axi_wr(`AST_OFF_MEAS_DECIMATION_SEL, 8'h0c);
        axi_rd(`AST_OFF_MEAS_DECIMATION_SEL, d, r);
        `CHK("decimation", 8'h0c, d[7:0])
        axi_rd(12'h100, d, r);
        `CHK("unmapped", {2'h2, 32'h0000_0000}, {r, d})
        axi_wr(`AST_OFF_RATE_CFG, 8'h05);
        for (k = 1; k < 4; k++)
        begin
            axi_wr(`AST_OFF_MAIN_CFG, {k[1:0], k[0], 5'h01});
            repeat (3) @(posedge aclk);
            `CHK("axis", {k[1:0], k[0]}, {test_axis_select, deflection_polarity})
            `CHK("override", 9'h100, {self_test_on, eff_rate_cfg})
        end
        axi_wr(`AST_OFF_MAIN_CFG, 8'h00);
        repeat (3) @(posedge aclk);
        `CHK("restore", 9'h005, {self_test_on, eff_rate_cfg})
        for (k = 0; k < 4; k++)
        begin
            axi_wr(`AST_OFF_MAIN_CFG, 8'h00);
            axi_wr(`AST_OFF_MEAS_DECIMATION_SEL, {4'h0, dec_t[k]});
            axi_wr(`AST_OFF_IDLE_PHASE_LEN, {3'h0, (k == 2) ? 5'h1f : 5'h00});
            axi_wr(`AST_OFF_MAIN_CFG, 8'h41);
            wait_tick(c0);
            wait_tick(c1);
            p = (1 << ((dec_t[k] > 12) ? 12 : dec_t[k])) * ((k == 2) ? 35 : 4);
            `CHK("period", p, c1)
            // bus answer and entry detection add up to two cycles
            `CHK("first tick", 1'b1, c0 >= p && c0 <= p + 2)
        end
        axi_wr(`AST_OFF_MEAS_DECIMATION_SEL, 8'h00);
        axi_wr(`AST_OFF_INT_EN, 8'h00);
        ev <= 8'h7d;
        repeat (4) @(posedge aclk);
        `CHK("masked", 2'h0, {irq_line_one, irq_line_two})
        for (j = 0; j < 7; j++)
        begin
            if (j != 1)
            begin
                ev <= 8'h01 << j;
                axi_wr(`AST_OFF_INT_EN, 8'h01 << j);
                repeat (3) @(posedge aclk);
                `CHK("line one", 2'h2, {irq_line_one, irq_line_two})
                axi_wr(`AST_OFF_PIN_ROUTE, 8'h01 << j);
                repeat (3) @(posedge aclk);
                `CHK("line two", 2'h1, {irq_line_one, irq_line_two})
                ev <= 8'h00;
                axi_wr(`AST_OFF_PIN_ROUTE, 8'h00);
            end
        end
        axi_wr(`AST_OFF_MAIN_CFG, 8'h00);
        axi_wr(`AST_OFF_INT_EN, 8'h80);
        // earlier ticks left the flag set; clear it so the line starts quiet
        axi_rd(`AST_OFF_STATUS, d, r);
        repeat (3) @(posedge aclk);
        `CHK("ready idle", 2'h0, {irq_line_one, irq_line_two})
        host_rst <= 1'b1;
        axi_wr(`AST_OFF_MAIN_CFG, 8'h41);
        host_rst <= 1'b0;
        for (j = 0; j < 300 && !sample_ok; j++)
            @(posedge aclk);
        hang(j == 300);
        `CHK("ready line one", 2'h2, {irq_line_one, irq_line_two})
        axi_wr(`AST_OFF_MAIN_CFG, 8'h40);
        axi_wr(`AST_OFF_PIN_ROUTE, 8'h80);
        repeat (3) @(posedge aclk);
        `CHK("ready line two", 2'h1, {irq_line_one, irq_line_two})
        axi_rd(`AST_OFF_STATUS, d, r);
        `CHK("ready flag", 1'b1, d[0])
        repeat (3) @(posedge aclk);
        `CHK("ready cleared", 2'h0, {irq_line_one, irq_line_two})
        test_done;
    end
endmodule
